// ===== verilog/servo_stop_regs.svh
// Register offsets, field positions, reset values and limits of the stop and clamp block
`ifndef SERVO_STOP_REGS_SVH
`define SERVO_STOP_REGS_SVH

// Word-aligned byte offsets
`define REG_CTRL          8'h00
`define REG_CLAMP_LEVEL   8'h04
`define REG_MAX_SPEED     8'h08
`define REG_OFFSET        8'h0C
`define REG_STATUS        8'h10

// Control register fields
`define CTRL_STOP_LSB     0
`define CTRL_METHOD_LSB   4
`define CTRL_ALLOC_BIT    8
`define CTRL_AUTO_BIT     9

// Status register fields
`define STAT_DRIVE_BIT    0
`define STAT_BRAKE_BIT    1
`define STAT_CLAMP_BIT    2
`define STAT_SERIAL_BIT   3
`define STAT_STATE_LSB    4

// Reset values and limits
`define CLAMP_LEVEL_RST   16'h000A
`define CLAMP_LEVEL_MAX   16'h2710
`define MAX_SPEED_RST     16'h0BB8
`define STOP_SPEED_RPM    16'h0002
`define PULSE_TOLERANCE   16'h0001

`endif

// ===== verilog/servo_stop_pkg.sv
// Types shared by the stop and zero clamp logic
`default_nettype none
package servo_stop_pkg;

  typedef enum logic [3:0]
  {
    ST_RUN     = 4'b0001,
    ST_BRAKING = 4'b0010,
    ST_BRAKED  = 4'b0100,
    ST_FREE    = 4'b1000
  } run_state_t;

  typedef enum logic [1:0]
  {
    STOP_BRAKE_HOLD    = 2'h0,
    STOP_BRAKE_RELEASE = 2'h1,
    STOP_COAST         = 2'h2
  } stop_mode_t;

  typedef enum logic [3:0]
  {
    METHOD_SPEED  = 4'h0,
    METHOD_CLAMP  = 4'hA,
    METHOD_SERIAL = 4'hD
  } method_t;

  typedef struct packed
  {
    run_state_t  fsm;
    logic [1:0]  stop_mode_select;
    logic [3:0]  control_method_select;
    logic        clamp_allocated;
    logic [15:0] zero_clamp_speed_level;
    logic [15:0] max_speed;
    logic [15:0] ref_offset;
    logic        clamp;
    logic [15:0] clamp_pos;
    logic [15:0] speed_cmd;
    logic [15:0] torque_cmd;
    logic [15:0] pos_target;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;

endpackage
`default_nettype wire

// ===== verilog/servo_stop_ctrl.sv
// Servo-off stop sequencing, zero clamp loop, reference offset and APB register file
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "servo_stop_regs.svh"

module servo_stop_ctrl
#(
  parameter int CLAMP_SHIFT = 2
)
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SERVO_ON_N,
  input  wire logic        ALARM,
  input  wire logic        POWER_OK,
  input  wire logic        ZERO_CLAMP_REQUEST_N,
  input  wire logic [15:0] REF_RAW,
  input  wire logic [15:0] MOTOR_SPEED,
  input  wire logic [15:0] ENCODER_POS,
  input  wire logic        SERIAL_VALID,
  input  wire logic [15:0] SERIAL_POSITION,
  input  wire logic [15:0] SERIAL_TORQUE,
  output logic             DRIVE_ENABLE,
  output logic             WINDING_SHORT_BRAKE,
  output logic             CLAMP_ACTIVE,
  output logic             SERIAL_SELECT,
  output logic [15:0]      SPEED_CMD,
  output logic [15:0]      TORQUE_CMD,
  output logic [15:0]      POSITION_TARGET
);

  servo_stop_pkg::state_t st;
  servo_stop_pkg::state_t next_st;

  logic        run_ok;
  logic        stopped;
  logic        clamp_cond;
  logic        method_ok;
  logic [15:0] ref_corr;
  logic [15:0] ref_abs;
  logic [15:0] eff_level;
  logic [15:0] pos_err;
  logic [15:0] err_abs;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        serial_mode;
  logic [31:0] status_word;

  // Magnitude of a two's complement word
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction

  // Servo may run only with request on, no alarm, power present
  assign run_ok  = !SERVO_ON_N && !ALARM && POWER_OK;
  assign stopped = mag(MOTOR_SPEED) <= `STOP_SPEED_RPM;

  // Reference with offset removed
  assign ref_corr  = REF_RAW - st.ref_offset;
  assign ref_abs   = mag(ref_corr);
  assign eff_level = (st.zero_clamp_speed_level > st.max_speed) ? st.max_speed
                   : st.zero_clamp_speed_level;

  // Clamp qualifiers: method A, or method 0 with the request allocated
  assign method_ok = (st.control_method_select == servo_stop_pkg::METHOD_CLAMP)
                   || (st.clamp_allocated
                       && st.control_method_select == servo_stop_pkg::METHOD_SPEED);
  assign clamp_cond = method_ok && !ZERO_CLAMP_REQUEST_N
                    && ref_abs < eff_level && st.fsm == servo_stop_pkg::ST_RUN;
  assign serial_mode = st.control_method_select == servo_stop_pkg::METHOD_SERIAL;

  // Position error of the internal clamp loop
  assign pos_err = st.clamp_pos - ENCODER_POS;
  assign err_abs = mag(pos_err);

  // Bus strobes and decode
  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE;
  assign addr_ok  = PADDR == `REG_CTRL || PADDR == `REG_CLAMP_LEVEL
                  || PADDR == `REG_MAX_SPEED || PADDR == `REG_OFFSET
                  || PADDR == `REG_STATUS;

  // Status word built from live state
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`STAT_DRIVE_BIT] = DRIVE_ENABLE;
    status_word[`STAT_BRAKE_BIT] = WINDING_SHORT_BRAKE;
    status_word[`STAT_CLAMP_BIT] = st.clamp;
    status_word[`STAT_SERIAL_BIT] = serial_mode;
    status_word[`STAT_STATE_LSB +: 4] = st.fsm;
  end

  // Next state of the whole block
  always_comb
  begin
    next_st = st;
    // Stop sequencing
    case (st.fsm)
      servo_stop_pkg::ST_RUN:
      begin
        if (!run_ok)
        begin
          if (stopped)
            next_st.fsm = servo_stop_pkg::ST_FREE;
          else if (st.stop_mode_select == servo_stop_pkg::STOP_BRAKE_HOLD
                   || st.stop_mode_select == servo_stop_pkg::STOP_BRAKE_RELEASE)
            next_st.fsm = servo_stop_pkg::ST_BRAKING;
          else
            next_st.fsm = servo_stop_pkg::ST_FREE;
        end
      end
      servo_stop_pkg::ST_BRAKING:
      begin
        if (stopped)
        begin
          if (st.stop_mode_select == servo_stop_pkg::STOP_BRAKE_HOLD)
            next_st.fsm = servo_stop_pkg::ST_BRAKED;
          else
            next_st.fsm = servo_stop_pkg::ST_FREE;
        end
      end
      servo_stop_pkg::ST_BRAKED:
      begin
        if (run_ok)
          next_st.fsm = servo_stop_pkg::ST_RUN;
      end
      servo_stop_pkg::ST_FREE:
      begin
        if (run_ok)
          next_st.fsm = servo_stop_pkg::ST_RUN;
      end
      default:
      begin
        next_st.fsm = servo_stop_pkg::ST_FREE;
      end
    endcase

    // Clamp entry captures the position to hold
    next_st.clamp = clamp_cond;
    if (clamp_cond && !st.clamp)
      next_st.clamp_pos = ENCODER_POS;

    // Speed command source
    if (st.fsm != servo_stop_pkg::ST_RUN || serial_mode)
      next_st.speed_cmd = 16'h0000;
    else if (st.clamp && clamp_cond)
      next_st.speed_cmd = (err_abs <= `PULSE_TOLERANCE) ? 16'h0000
                        : 16'(pos_err <<< CLAMP_SHIFT);
    else if (clamp_cond)
      next_st.speed_cmd = 16'h0000;
    else
      next_st.speed_cmd = ref_corr;

    // Serial commands replace analog references
    if (!serial_mode || st.fsm != servo_stop_pkg::ST_RUN)
      next_st.torque_cmd = 16'h0000;
    else if (SERIAL_VALID)
    begin
      next_st.torque_cmd = SERIAL_TORQUE;
      next_st.pos_target = SERIAL_POSITION;
    end

    // Register writes take effect at the access edge
    next_st.pslverr = 1'b0;
    if (wr_en)
    begin
      case (PADDR)
        `REG_CTRL:
        begin
          next_st.stop_mode_select = PWDATA[`CTRL_STOP_LSB +: 2];
          next_st.control_method_select = PWDATA[`CTRL_METHOD_LSB +: 4];
          next_st.clamp_allocated = PWDATA[`CTRL_ALLOC_BIT];
          if (PWDATA[`CTRL_AUTO_BIT])
            next_st.ref_offset = REF_RAW;
        end
        `REG_CLAMP_LEVEL:
        begin
          next_st.zero_clamp_speed_level = (PWDATA[15:0] > `CLAMP_LEVEL_MAX)
                                         ? `CLAMP_LEVEL_MAX : PWDATA[15:0];
        end
        `REG_MAX_SPEED:
        begin
          next_st.max_speed = PWDATA[15:0];
        end
        `REG_OFFSET:
        begin
          next_st.ref_offset = PWDATA[15:0];
        end
        default:
        begin
          next_st.ref_offset = next_st.ref_offset;
        end
      endcase
    end

    // Read data and error prepared in the setup cycle
    if (rd_setup)
    begin
      next_st.pslverr = !addr_ok || (PWRITE && PADDR == `REG_STATUS);
      case (PADDR)
        `REG_CTRL:
          next_st.prdata = {23'h00_0000, st.clamp_allocated,
                            st.control_method_select, 2'h0, st.stop_mode_select};
        `REG_CLAMP_LEVEL:
          next_st.prdata = {16'h0000, st.zero_clamp_speed_level};
        `REG_MAX_SPEED:
          next_st.prdata = {16'h0000, st.max_speed};
        `REG_OFFSET:
          next_st.prdata = {16'h0000, st.ref_offset};
        `REG_STATUS:
          next_st.prdata = status_word;
        default:
          next_st.prdata = 32'h0000_0000;
      endcase
    end
    else if (PSEL && PENABLE)
      next_st.pslverr = st.pslverr;
  end

  // State register
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st.fsm <= servo_stop_pkg::ST_FREE;
      st.stop_mode_select <= 2'h0;
      st.control_method_select <= 4'h0;
      st.clamp_allocated <= 1'b0;
      st.zero_clamp_speed_level <= `CLAMP_LEVEL_RST;
      st.max_speed <= `MAX_SPEED_RST;
      st.ref_offset <= 16'h0000;
      st.clamp <= 1'b0;
      st.clamp_pos <= 16'h0000;
      st.speed_cmd <= 16'h0000;
      st.torque_cmd <= 16'h0000;
      st.pos_target <= 16'h0000;
      st.prdata <= 32'h0000_0000;
      st.pslverr <= 1'b0;
    end
    else
      st <= next_st;
  end

  // Outputs
  assign PREADY              = 1'b1;
  assign PRDATA              = st.prdata;
  assign PSLVERR             = st.pslverr && PSEL && PENABLE;
  assign DRIVE_ENABLE        = st.fsm == servo_stop_pkg::ST_RUN;
  assign WINDING_SHORT_BRAKE = st.fsm == servo_stop_pkg::ST_BRAKING
                             || st.fsm == servo_stop_pkg::ST_BRAKED;
  assign CLAMP_ACTIVE        = st.clamp;
  assign SERIAL_SELECT       = serial_mode;
  assign SPEED_CMD           = st.speed_cmd;
  assign TORQUE_CMD          = st.torque_cmd;
  assign POSITION_TARGET     = st.pos_target;

  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  property p_servo_off;
    !run_ok |=> !DRIVE_ENABLE;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("servo stayed on");

  property p_hold_brake;
    st.fsm == servo_stop_pkg::ST_BRAKING && stopped
      && st.stop_mode_select == servo_stop_pkg::STOP_BRAKE_HOLD
      |=> WINDING_SHORT_BRAKE && st.fsm == servo_stop_pkg::ST_BRAKED;
  endproperty
  a_hold_brake: assert property (p_hold_brake) else $error("brake not held");

  property p_release_brake;
    st.fsm == servo_stop_pkg::ST_BRAKING && stopped
      && st.stop_mode_select == servo_stop_pkg::STOP_BRAKE_RELEASE
      |=> !WINDING_SHORT_BRAKE;
  endproperty
  a_release_brake: assert property (p_release_brake) else $error("brake not released");

  property p_coast;
    DRIVE_ENABLE && !run_ok && st.stop_mode_select == servo_stop_pkg::STOP_COAST
      |=> !WINDING_SHORT_BRAKE ##1 !WINDING_SHORT_BRAKE || DRIVE_ENABLE;
  endproperty
  a_coast: assert property (p_coast) else $error("brake used in coast mode");

  property p_slow_coast;
    DRIVE_ENABLE && !run_ok && stopped |=> st.fsm == servo_stop_pkg::ST_FREE;
  endproperty
  a_slow_coast: assert property (p_slow_coast) else $error("slow motor was braked");

  property p_clamp_pull;
    st.clamp && clamp_cond && !st.fsm[1] && !pos_err[15] && err_abs > `PULSE_TOLERANCE
      |=> SPEED_CMD != 16'h0000 && !SPEED_CMD[15];
  endproperty
  a_clamp_pull: assert property (p_clamp_pull) else $error("clamp did not correct");

  property p_clamp_cond;
    ##1 CLAMP_ACTIVE == $past(clamp_cond);
  endproperty
  a_clamp_cond: assert property (p_clamp_cond) else $error("clamp state wrong");

  property p_clamp_req;
    ZERO_CLAMP_REQUEST_N || !DRIVE_ENABLE |=> !CLAMP_ACTIVE;
  endproperty
  a_clamp_req: assert property (p_clamp_req) else $error("clamp without request");

  property p_level_range;
    st.zero_clamp_speed_level <= `CLAMP_LEVEL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("clamp level out of range");

  property p_serial_cmd;
    serial_mode && DRIVE_ENABLE && SERIAL_VALID && !wr_en
      |=> TORQUE_CMD == $past(SERIAL_TORQUE) || !DRIVE_ENABLE;
  endproperty
  a_serial_cmd: assert property (p_serial_cmd) else $error("serial torque not taken");

  property p_auto_offset;
    wr_en && PADDR == `REG_CTRL && PWDATA[`CTRL_AUTO_BIT] |=> st.ref_offset == $past(REF_RAW);
  endproperty
  a_auto_offset: assert property (p_auto_offset) else $error("offset not captured");

  c_clamp: cover property (!CLAMP_ACTIVE ##1 CLAMP_ACTIVE);
  c_brake_stop: cover property (DRIVE_ENABLE ##1 WINDING_SHORT_BRAKE ##[1:50] !WINDING_SHORT_BRAKE);
  c_serial: cover property (SERIAL_SELECT && DRIVE_ENABLE && SERIAL_VALID);

endmodule

`default_nettype wire

// ===== dv/servo_host_model.sv
// Host side motor model: speed decays once drive is removed
`timescale 1ns/10ps
`default_nettype none

module servo_host_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        drive_en,
  input  wire logic        brake,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output logic [15:0]      speed
);
  // Winding brake stops fast, friction slowly
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      speed <= 16'h0000;
    else if (load)
      speed <= load_val;
    else if (!drive_en && brake)
      speed <= (speed > 16'h000A) ? speed - 16'h000A : 16'h0000;
    else if (!drive_en && speed != 16'h0000)
      speed <= speed - 16'h0001;
  end
endmodule
`default_nettype wire

// ===== dv/servo_stop_and_zero_clamp_tb.sv
// Self-checking bench for the stop and zero clamp block
`timescale 1ns/10ps
`default_nettype none

module servo_stop_and_zero_clamp_tb;
  logic        REF_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic        PREADY, PSLVERR;
  logic        SERVO_ON_N = 1'b1, ALARM = 1'b0, POWER_OK = 1'b1;
  logic        ZERO_CLAMP_REQUEST_N = 1'b1, SERIAL_VALID = 1'b0;
  logic [15:0] REF_RAW = 16'h0000, MOTOR_SPEED, ENCODER_POS = 16'h0100;
  logic [15:0] SERIAL_POSITION = 16'h0000, SERIAL_TORQUE = 16'h0000;
  logic        DRIVE_ENABLE, WINDING_SHORT_BRAKE, CLAMP_ACTIVE, SERIAL_SELECT;
  logic [15:0] SPEED_CMD, TORQUE_CMD, POSITION_TARGET;
  logic        spin = 1'b0;
  logic [15:0] spin_val = 16'h0000;
  int          bad_count = 0;
  int          num_checks = 0;

  servo_stop_ctrl DUT (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .SERVO_ON_N, .ALARM, .POWER_OK, .ZERO_CLAMP_REQUEST_N,
    .REF_RAW, .MOTOR_SPEED, .ENCODER_POS, .SERIAL_VALID, .SERIAL_POSITION, .SERIAL_TORQUE,
    .DRIVE_ENABLE, .WINDING_SHORT_BRAKE, .CLAMP_ACTIVE, .SERIAL_SELECT, .SPEED_CMD,
    .TORQUE_CMD, .POSITION_TARGET);

  servo_host_model host (.clk(REF_CLK), .nrst(NRST), .drive_en(DRIVE_ENABLE),
    .brake(WINDING_SHORT_BRAKE), .load(spin), .load_val(spin_val), .speed(MOTOR_SPEED));

  // Clock
  always #20 REF_CLK = ~REF_CLK;

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer, held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge REF_CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, exp_e});
  endtask

  task clk(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task regs_test();
    logic [31:0] r;
    logic e;
    rd(8'h00, 32'h0000_0000, 1'b0);
    rd(8'h04, 32'h0000_000A, 1'b0);
    rd(8'h08, 32'h0000_0BB8, 1'b0);
    rd(8'h10, 32'h0000_0080, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h10, 32'h0000_FFFF, r, e);
    check({31'h0, e}, 32'h0000_0001);
    wr(8'h04, 32'h0000_4E20);
    rd(8'h04, 32'h0000_2710, 1'b0);
    wr(8'h04, 32'h0000_000A);
    $display("registers done");
  endtask

  task stop_test(input logic [1:0] mode);
    wr(8'h00, {30'h0, mode});
    SERVO_ON_N <= 1'b0;
    clk(3);
    check(DRIVE_ENABLE, 1'b1);
    spin <= 1'b1; spin_val <= 16'h0064;
    clk(1);
    spin <= 1'b0; SERVO_ON_N <= 1'b1;
    clk(2);
    check(DRIVE_ENABLE, 1'b0);
    check(WINDING_SHORT_BRAKE, mode != 2'h2);
    while (MOTOR_SPEED > 16'h0002)
      clk(1);
    clk(2);
    check(WINDING_SHORT_BRAKE, mode == 2'h0);
    $display("stop mode %0d done", mode);
  endtask

  task cause_test();
    wr(8'h00, 32'h0000_0000);
    SERVO_ON_N <= 1'b0;
    clk(3);
    ALARM <= 1'b1;
    clk(2);
    check(DRIVE_ENABLE, 1'b0);
    check(WINDING_SHORT_BRAKE, 1'b0);
    ALARM <= 1'b0;
    clk(3);
    check(DRIVE_ENABLE, 1'b1);
    POWER_OK <= 1'b0;
    clk(2);
    check(DRIVE_ENABLE, 1'b0);
    POWER_OK <= 1'b1;
    $display("off causes done");
  endtask

  task clamp_test();
    wr(8'h00, 32'h0000_00A2);
    REF_RAW <= 16'h0005; ZERO_CLAMP_REQUEST_N <= 1'b0;
    clk(3);
    check(CLAMP_ACTIVE, 1'b1);
    ENCODER_POS <= 16'h0105;
    clk(3);
    check(SPEED_CMD, 16'hFFEC);
    ENCODER_POS <= 16'h00FB;
    clk(3);
    check(SPEED_CMD, 16'h0014);
    ENCODER_POS <= 16'h0101;
    clk(3);
    check(SPEED_CMD, 16'h0000);
    ZERO_CLAMP_REQUEST_N <= 1'b1;
    clk(3);
    check(CLAMP_ACTIVE, 1'b0);
    wr(8'h08, 32'h0000_0064);
    wr(8'h04, 32'h0000_1388);
    REF_RAW <= 16'h0096; ZERO_CLAMP_REQUEST_N <= 1'b0;
    clk(3);
    check(CLAMP_ACTIVE, 1'b0);
    REF_RAW <= 16'h0032;
    clk(3);
    check(CLAMP_ACTIVE, 1'b1);
    wr(8'h00, 32'h0000_0102);
    clk(3);
    check(CLAMP_ACTIVE, 1'b1);
    wr(8'h00, 32'h0000_0002);
    clk(3);
    check(CLAMP_ACTIVE, 1'b0);
    $display("zero clamp done");
  endtask

  task serial_test();
    wr(8'h00, 32'h0000_00D2);
    ZERO_CLAMP_REQUEST_N <= 1'b1;
    SERIAL_POSITION <= 16'h1234; SERIAL_TORQUE <= 16'h0056; SERIAL_VALID <= 1'b1;
    clk(1);
    SERIAL_VALID <= 1'b0;
    clk(2);
    check(SERIAL_SELECT, 1'b1);
    check(POSITION_TARGET, 16'h1234);
    check(TORQUE_CMD, 16'h0056);
    check(SPEED_CMD, 16'h0000);
    REF_RAW <= 16'h007B;
    wr(8'h00, 32'h0000_0202);
    rd(8'h0C, 32'h0000_007B, 1'b0);
    check(SPEED_CMD, 16'h0000);
    wr(8'h0C, 32'h0000_0011);
    rd(8'h0C, 32'h0000_0011, 1'b0);
    check(SPEED_CMD, 16'h006A);
    $display("serial and offset done");
  endtask

  // Main sequence
  initial
  begin
    clk(12);
    NRST <= 1'b1;
    regs_test();
    stop_test(2'h0);
    stop_test(2'h1);
    stop_test(2'h2);
    cause_test();
    clamp_test();
    serial_test();
    results();
  end

  // Watchdog
  initial
  begin
    clk(20000);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
